// file: rtl/gsm_pkg.sv
// gsm_pkg: shared constants and carrier types for the gci signaling/monitor block
package gsm_pkg;

    // ************************************************************
    // packet and slot layout
    // ************************************************************
    localparam logic [1:0] SLOT_MON = 2'h2;
    localparam logic [1:0] SLOT_SC = 2'h3;
    localparam logic [4:0] PKT_LAST_BIT = 5'h1f;
    localparam logic [7:0] BIT_CNT_RST = 8'h00;

    // ************************************************************
    // control field and system state
    // ************************************************************
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [1:0] SS_IDLE = 2'h1;
    localparam logic [1:0] SS_ACTIVE = 2'h2;
    localparam logic [7:0] IND_RST = 8'h03;

    // ************************************************************
    // monitor channel
    // ************************************************************
    localparam logic [6:0] ADDR_PFX = 7'h40;
    localparam logic [7:0] ADDR_CIC = 8'h80;
    localparam logic [7:0] CMD_CIC = 8'h00;
    localparam logic [3:0] MAX_DATA = 4'he;
    localparam logic [4:0] RX_MAX = 5'h10;
    localparam logic [4:0] RX_MIN = 5'h02;
    localparam logic [1:0] ACK_FRAMES = 2'h2;
    localparam logic [3:0] TX_TIMEOUT = 4'h8;
    localparam logic [1:0] EOM_LAST = 2'h1;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_EOM = 3'b100
    } gsm_tx_t;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } gsm_word_t;

    typedef struct packed {
        logic dcl_s1, dcl_s2, dcl_d;
        logic fsc_s1, fsc_s2, fsc_d;
        logic dd_s1, dd_s2;
        logic [2:0] sel_s1, sel_s2;
        logic [7:0] bit_cnt, mon_sh, c_sh, ind, mon_out;
        logic du, du_oe;
        logic [5:0] ctrl, sec;
        logic pend, ring, line_in_use;
        logic [15:0] liu_cnt;
        logic [7:0] tog, sig_prev;
        logic mx_up, mx_prev, mr_prev;
        logic [7:0] prev_byte, last_acc, last_addr;
        logic armed, rx_active, need_eom, cic_pend;
        logic [4:0] rx_cnt, drain_len, drain_idx;
        logic [1:0] ack_cnt, eom_cnt;
        logic [15:0][7:0] buffer;
        gsm_tx_t tx;
        logic tx_cic, tx_idx, want_next, user_last;
        logic [3:0] tx_sent, tx_frames;
        logic framed;
    } gsm_core_t;

endpackage : gsm_pkg

// file: rtl/gsm_fifo.sv
// gsm_fifo: parameterised valid/ready fifo for received monitor words
`timescale 1ns/100ps
`default_nettype none
module gsm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } gsm_fifo_st_t;

    gsm_fifo_st_t st_ff;
    gsm_fifo_st_t nxt_st;
    logic full;
    logic empty;

    assign empty = (st_ff.wr == st_ff.rd);
    assign full = (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]) &&
        (st_ff.wr[AW] != st_ff.rd[AW]);
    assign o_in_ready = ~full;
    assign o_out_valid = ~empty;
    assign o_out_data = st_ff.mem[st_ff.rd[AW-1:0]];

    always_comb begin
        nxt_st = st_ff;
        if (i_in_valid && !full) begin
            nxt_st.mem[st_ff.wr[AW-1:0]] = i_in_data;
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (i_out_ready && !empty) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    chk_fifo_no_over: assert property (@(posedge i_core_clk)
        disable iff (i_rst) full |=> !(st_ff.wr == st_ff.rd))
        else $error("fifo pointer wrapped while full");
endmodule : gsm_fifo
`default_nettype wire

// file: rtl/gsm_chan.sv
// gsm_chan: gci signaling/control field and monitor channel engine
`timescale 1ns/100ps
`default_nettype none
module gsm_chan
    import gsm_pkg::*;
#(
    parameter logic [7:0] ID_BYTE1 = 8'h81, // arbitrary value
    parameter logic [7:0] ID_BYTE2 = 8'h85  // arbitrary value
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // gci highway pins
    input wire logic i_dcl,
    input wire logic i_fsc,
    input wire logic i_dd,
    input wire logic [2:0] i_packet_sel,
    output logic o_du,
    output logic o_du_oe,
    // control field outputs
    output logic [2:0] o_gp_latch,
    output logic [1:0] o_system_state_field,
    output logic o_supervision_en,
    output logic o_codec_en,
    // supervision inputs and outputs
    input wire logic [7:0] i_sig_status,
    input wire logic [7:0] i_sig_mask,
    input wire logic i_sig_clear,
    input wire logic i_ring_detect,
    input wire logic i_line_below,
    input wire logic [15:0] i_line_use_duration,
    output logic o_signaling_summary,
    output logic o_line_in_use,
    // received monitor message stream
    output logic o_mon_valid,
    input wire logic i_mon_ready,
    output logic [7:0] o_mon_data,
    output logic o_mon_last,
    // read answer bytes
    input wire logic i_resp_valid,
    input wire logic [7:0] i_resp_data,
    input wire logic i_resp_last,
    output logic o_resp_ready
);
    gsm_core_t st_ff;
    gsm_core_t nxt_st;
    logic resp_take;
    logic fifo_in_ready;
    logic push_valid;
    gsm_word_t push_word;
    gsm_word_t pop_word;
    logic rise, fall, first, ours, proc, mx, mr, commit, abort, acc_ok, ack;
    logic [7:0] idx, fidx, cin, mon;
    logic [5:0] pat;
    logic [7:0] new_tog;

    // ************************************************************
    // received message buffer toward the user
    // ************************************************************
    assign push_valid = (st_ff.drain_idx != st_ff.drain_len);
    assign push_word.data = st_ff.buffer[st_ff.drain_idx[3:0]];
    assign push_word.last = (st_ff.drain_idx + 5'h01 == st_ff.drain_len);

    gsm_fifo #(
        .WIDTH($bits(gsm_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_in_valid(push_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(push_word),
        .o_out_valid(o_mon_valid),
        .i_out_ready(i_mon_ready),
        .o_out_data(pop_word)
    );

    assign o_mon_data = pop_word.data;
    assign o_mon_last = pop_word.last;
    assign o_resp_ready = resp_take;
    assign o_du = st_ff.du;
    assign o_du_oe = st_ff.du_oe;
    assign o_gp_latch = st_ff.ctrl[5:3];
    assign o_system_state_field = st_ff.ctrl[2:1];
    assign o_signaling_summary = |st_ff.tog;
    assign o_line_in_use = st_ff.line_in_use;
    always_comb begin
        o_supervision_en = (st_ff.ctrl[2:1] == SS_IDLE) ||
            (st_ff.ctrl[2:1] == SS_ACTIVE);
        o_codec_en = (st_ff.ctrl[2:1] == SS_ACTIVE);
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        resp_take = 1'b0;
        commit = 1'b0;
        abort = 1'b0;
        acc_ok = 1'b0;
        ack = 1'b0;
        nxt_st.dcl_s1 = i_dcl;
        nxt_st.dcl_s2 = st_ff.dcl_s1;
        nxt_st.dcl_d = st_ff.dcl_s2;
        nxt_st.fsc_s1 = i_fsc;
        nxt_st.fsc_s2 = st_ff.fsc_s1;
        nxt_st.dd_s1 = i_dd;
        nxt_st.dd_s2 = st_ff.dd_s1;
        nxt_st.sel_s1 = i_packet_sel;
        nxt_st.sel_s2 = st_ff.sel_s1;
        rise = st_ff.dcl_s2 & ~st_ff.dcl_d;
        fall = ~st_ff.dcl_s2 & st_ff.dcl_d;
        first = st_ff.fsc_s2 & ~st_ff.fsc_d;
        idx = first ? BIT_CNT_RST : st_ff.bit_cnt;
        fidx = st_ff.bit_cnt;
        ours = (idx[7:5] == st_ff.sel_s2);
        // a frame cut short by reset release is not trusted
        proc = rise && ours && (idx[4:0] == PKT_LAST_BIT) &&
            (st_ff.framed || first);
        cin = {st_ff.c_sh[6:0], st_ff.dd_s2};
        pat = cin[6:1];
        mx = cin[0];
        mr = cin[1];
        mon = st_ff.mon_sh;

        // sticky toggles, a new toggle wins over the clear
        new_tog = (i_sig_status ^ st_ff.sig_prev) & ~i_sig_mask;
        nxt_st.sig_prev = i_sig_status;
        nxt_st.tog = (st_ff.tog & ~{8{i_sig_clear}}) | new_tog;

        if (push_valid && fifo_in_ready) begin
            nxt_st.drain_idx = st_ff.drain_idx + 5'h01;
        end

        if (rise) begin
            nxt_st.fsc_d = st_ff.fsc_s2;
            nxt_st.bit_cnt = idx + 8'h01;
            if (first) begin
                nxt_st.framed = 1'b1;
                nxt_st.ring = i_ring_detect;
                if (i_line_below != st_ff.line_in_use) begin
                    if (st_ff.liu_cnt >= i_line_use_duration) begin
                        nxt_st.line_in_use = i_line_below;
                        nxt_st.liu_cnt = '0;
                    end else begin
                        nxt_st.liu_cnt = st_ff.liu_cnt + 16'h0001;
                    end
                end else begin
                    nxt_st.liu_cnt = '0;
                end
            end
            if (ours && idx[4:3] == SLOT_MON) begin
                nxt_st.mon_sh = {st_ff.mon_sh[6:0], st_ff.dd_s2};
            end
            if (ours && idx[4:3] == SLOT_SC) begin
                nxt_st.c_sh = cin;
            end
        end

        if (fall) begin
            if (st_ff.framed && fidx[7:5] == st_ff.sel_s2 && fidx[4]) begin
                nxt_st.du_oe = 1'b1;
                if (fidx[3]) begin
                    nxt_st.du = st_ff.ind[3'h7 - fidx[2:0]];
                end else begin
                    nxt_st.du = st_ff.mon_out[3'h7 - fidx[2:0]];
                end
            end else begin
                nxt_st.du_oe = 1'b0;
                nxt_st.du = 1'b0;
            end
        end

        if (proc) begin
            // two-frame security filter on the control pattern
            if (!st_ff.pend) begin
                if (pat != st_ff.ctrl) begin
                    nxt_st.sec = pat;
                    nxt_st.pend = 1'b1;
                end
            end else if (pat == st_ff.sec) begin
                nxt_st.ctrl = pat;
                nxt_st.pend = 1'b0;
            end else if (pat == st_ff.ctrl) begin
                nxt_st.pend = 1'b0;
            end else begin
                nxt_st.sec = pat;
            end

            nxt_st.mx_prev = mx;
            nxt_st.mr_prev = mr;
            nxt_st.prev_byte = mon;
            if (st_ff.ack_cnt != 2'h0) begin
                nxt_st.ack_cnt = st_ff.ack_cnt - 2'h1;
            end

            // monitor receiver
            if (mx) begin
                if (st_ff.mx_prev) begin
                    commit = st_ff.rx_active;
                    nxt_st.rx_active = 1'b0;
                    nxt_st.need_eom = 1'b0;
                end
            end else if (st_ff.mx_prev) begin
                if (st_ff.rx_active) begin
                    abort = 1'b1;
                end else if (!st_ff.need_eom && !push_valid) begin
                    nxt_st.rx_active = 1'b1;
                    nxt_st.rx_cnt = '0;
                    nxt_st.armed = 1'b1;
                end
            end else if (st_ff.rx_active) begin
                acc_ok = (st_ff.armed || mon != st_ff.last_acc) &&
                    (mon == st_ff.prev_byte) && (st_ff.ack_cnt == 2'h0);
                if (mon != st_ff.last_acc) begin
                    nxt_st.armed = 1'b1;
                end
                if (acc_ok) begin
                    if (st_ff.rx_cnt == RX_MAX) begin
                        abort = 1'b1;
                    end else begin
                        nxt_st.buffer[st_ff.rx_cnt[3:0]] = mon;
                        nxt_st.rx_cnt = st_ff.rx_cnt + 5'h01;
                        nxt_st.last_acc = mon;
                        nxt_st.armed = 1'b0;
                        nxt_st.ack_cnt = ACK_FRAMES;
                    end
                end
            end
            if (abort) begin
                nxt_st.rx_active = 1'b0;
                nxt_st.ack_cnt = 2'h0;
                nxt_st.cic_pend = 1'b0;
            end
            if (commit && st_ff.rx_cnt >= RX_MIN &&
                st_ff.buffer[0][7:1] == ADDR_PFX) begin
                if (st_ff.buffer[0] == ADDR_CIC &&
                    st_ff.buffer[1] == CMD_CIC && st_ff.rx_cnt == RX_MIN) begin
                    nxt_st.cic_pend = 1'b1;
                end else if (st_ff.buffer[0][0]) begin
                    nxt_st.drain_len = st_ff.rx_cnt;
                    nxt_st.drain_idx = '0;
                    nxt_st.last_addr = st_ff.buffer[0];
                end
            end

            // monitor transmitter
            ack = !mr && st_ff.mr_prev;
            case (st_ff.tx)
                TX_IDLE: begin
                    nxt_st.mx_up = 1'b1;
                    nxt_st.tx_frames = '0;
                    nxt_st.tx_sent = '0;
                    nxt_st.want_next = 1'b0;
                    nxt_st.user_last = 1'b0;
                    nxt_st.tx_idx = 1'b0;
                    if (st_ff.cic_pend) begin
                        nxt_st.cic_pend = 1'b0;
                        nxt_st.tx = TX_SEND;
                        nxt_st.tx_cic = 1'b1;
                        nxt_st.mon_out = ID_BYTE1;
                        nxt_st.mx_up = 1'b0;
                    end else if (i_resp_valid) begin
                        nxt_st.tx = TX_SEND;
                        nxt_st.tx_cic = 1'b0;
                        nxt_st.mon_out = st_ff.last_addr;
                        nxt_st.mx_up = 1'b0;
                    end
                end
                TX_SEND: begin
                    if (st_ff.tx_frames != TX_TIMEOUT) begin
                        nxt_st.tx_frames = st_ff.tx_frames + 4'h1;
                    end
                    if (ack && st_ff.tx_frames == 4'h0) begin
                        nxt_st.tx = TX_EOM;
                    end else if (ack || st_ff.want_next) begin
                        if (st_ff.tx_cic) begin
                            if (!st_ff.tx_idx) begin
                                nxt_st.mon_out = ID_BYTE2;
                                nxt_st.tx_idx = 1'b1;
                                nxt_st.tx_frames = '0;
                            end else begin
                                nxt_st.tx = TX_EOM;
                            end
                        end else if (st_ff.user_last ||
                            st_ff.tx_sent == MAX_DATA) begin
                            nxt_st.tx = TX_EOM;
                        end else if (i_resp_valid) begin
                            resp_take = 1'b1;
                            nxt_st.mon_out = i_resp_data;
                            nxt_st.tx_sent = st_ff.tx_sent + 4'h1;
                            nxt_st.user_last = i_resp_last;
                            nxt_st.tx_frames = '0;
                            nxt_st.want_next = 1'b0;
                        end else begin
                            nxt_st.want_next = 1'b1;
                        end
                    end else if (st_ff.tx_frames == TX_TIMEOUT) begin
                        nxt_st.tx = TX_EOM;
                    end
                    if (nxt_st.tx == TX_EOM) begin
                        nxt_st.mx_up = 1'b1;
                        nxt_st.eom_cnt = '0;
                    end
                end
                TX_EOM: begin
                    nxt_st.mx_up = 1'b1;
                    nxt_st.eom_cnt = st_ff.eom_cnt + 2'h1;
                    if (st_ff.eom_cnt == EOM_LAST) begin
                        nxt_st.tx = TX_IDLE;
                        if (st_ff.tx_cic) begin
                            nxt_st.need_eom = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_st.tx = TX_IDLE;
                end
            endcase
            nxt_st.ind = {3'h0, |st_ff.tog, st_ff.ring, st_ff.line_in_use,
                nxt_st.ack_cnt == 2'h0, nxt_st.mx_up};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RST;
            st_ff.ind <= IND_RST;
            st_ff.mx_up <= 1'b1;
            st_ff.mx_prev <= 1'b1;
            st_ff.mr_prev <= 1'b1;
            st_ff.tx <= TX_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_state_decode: assert property (o_codec_en |-> o_supervision_en &&
        o_system_state_field == SS_ACTIVE)
        else $error("codec on outside active state");
    chk_ctrl_hold: assert property ($changed(st_ff.ctrl) |->
        $past(proc) && $past(st_ff.pend))
        else $error("control changed without confirmation");
    chk_pend_clear: assert property (proc && st_ff.pend &&
        (pat == st_ff.sec || pat == st_ff.ctrl) |=> !st_ff.pend)
        else $error("pending latch not cleared");
    chk_pend_keep: assert property (proc && st_ff.pend &&
        pat != st_ff.sec && pat != st_ff.ctrl |=> st_ff.pend &&
        st_ff.ctrl == $past(st_ff.ctrl))
        else $error("third pattern disturbed control");
    chk_ind_zero: assert property (st_ff.ind[7:5] == 3'h0)
        else $error("upstream indication top bits set");
    chk_summary_clr: assert property (i_sig_clear && new_tog == 8'h00
        |=> !o_signaling_summary)
        else $error("summary survived clear");
    chk_ack_frames: assert property (proc && acc_ok &&
        st_ff.rx_cnt != RX_MAX |=> st_ff.ack_cnt == ACK_FRAMES &&
        !st_ff.ind[1])
        else $error("byte accepted without acknowledge");
    chk_du_slot: assert property (o_du_oe |->
        st_ff.sel_s2 == $past(st_ff.bit_cnt[7:5]) || !$past(fall))
        else $error("upstream driven outside own packet");
    chk_tx_limit: assert property (st_ff.tx_sent <= MAX_DATA)
        else $error("too many answer bytes");
    chk_eom_high: assert property (st_ff.tx == TX_EOM |-> st_ff.mx_up)
        else $error("mx low during end of message");
endmodule : gsm_chan
`default_nettype wire

// file: tb/gsm_hwy_model.sv
// gsm_hwy_model: upstream gci highway controller for the bench
`timescale 1ns/100ps
`default_nettype none
module gsm_hwy_model #(
    parameter int PKT = 1
) (
    // highway pins
    output logic o_dcl,
    output logic o_fsc,
    output logic o_dd,
    input wire logic i_du,
    input wire logic i_du_oe,
    // bytes sent down, bytes seen up, frame count
    input wire logic [7:0] i_c_byte,
    input wire logic [7:0] i_m_byte,
    output logic [7:0] o_up_ind,
    output logic [7:0] o_up_mon,
    output logic [7:0] o_frames
);
    logic [7:0] sh_m;
    logic [7:0] sh_i;
    int s;
    initial begin
        {o_dcl, o_fsc, o_dd, o_frames} = '0;
        {o_up_ind, o_up_mon, sh_m, sh_i} = '1;
        forever begin
            for (int b = 0; b < 256; b++) begin
                s = b - PKT * 32;
                o_dcl = 1'b0;
                o_fsc = (b == 0);
                if (s >= 16 && s < 24) begin
                    o_dd = i_m_byte[23 - s];
                end else if (s >= 24 && s < 32) begin
                    o_dd = i_c_byte[31 - s];
                end else begin
                    o_dd = ~o_dd;
                end
                #80 o_dcl = 1'b1;
                // a released du reads as the idle high level
                if (s >= 16 && s < 24) begin
                    sh_m = {sh_m[6:0], i_du_oe ? i_du : 1'b1};
                end else if (s >= 24 && s < 32) begin
                    sh_i = {sh_i[6:0], i_du_oe ? i_du : 1'b1};
                end
                #80;
            end
            o_up_mon = sh_m;
            o_up_ind = sh_i;
            o_frames = o_frames + 8'h01;
        end
    end
endmodule : gsm_hwy_model
`default_nettype wire

// file: tb/gsm_chan_bench.sv
// gsm_chan_bench: self-checking bench for the gci signaling/monitor block
`timescale 1ns/100ps
`default_nettype none
module gsm_chan_bench;
    logic clk, rst, dcl, fsc, dd, du, du_oe, sig_clear, ring, below, line_in_use;
    logic mon_valid, mon_ready, mon_last, resp_valid, resp_last, resp_ready;
    logic sup_en, codec_en, summary;
    logic [2:0] gp;
    logic [1:0] ss;
    logic [7:0] sig_status, sig_mask, mon_data, resp_data, c_byte, m_byte;
    logic [7:0] up_ind, up_mon, frames;
    int err_count, n_tests, cycles, n_resp;
`define CHK(name, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", name, e, a); end end
    gsm_chan i_dut (.i_core_clk(clk), .i_rst(rst), .i_dcl(dcl), .i_fsc(fsc),
        .i_dd(dd), .i_packet_sel(3'h1), .o_du(du), .o_du_oe(du_oe),
        .o_gp_latch(gp), .o_system_state_field(ss), .o_codec_en(codec_en),
        .o_supervision_en(sup_en), .i_sig_status(sig_status),
        .i_sig_mask(sig_mask), .i_sig_clear(sig_clear), .i_ring_detect(ring),
        .i_line_below(below), .i_line_use_duration(16'h0002),
        .o_signaling_summary(summary), .o_line_in_use(line_in_use),
        .o_mon_valid(mon_valid), .i_mon_ready(mon_ready),
        .o_mon_data(mon_data), .o_mon_last(mon_last),
        .i_resp_valid(resp_valid), .i_resp_data(resp_data),
        .i_resp_last(resp_last), .o_resp_ready(resp_ready));
    gsm_hwy_model #(.PKT(1)) i_hwy (.o_dcl(dcl), .o_fsc(fsc), .o_dd(dd),
        .i_du(du), .i_du_oe(du_oe), .i_c_byte(c_byte), .i_m_byte(m_byte),
        .o_up_ind(up_ind), .o_up_mon(up_mon), .o_frames(frames));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // release an answer byte once taken; cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (resp_ready === 1'b1 && resp_valid) begin
            resp_valid <= 1'b0;
            n_resp++;
        end
        if (cycles == 26 * 5120) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    // ****************
    // frame and scenarios
    // ****************
    task automatic frame(input logic [7:0] c, input logic [7:0] m);
        logic [7:0] f;
        @(negedge clk);
        c_byte = c;
        m_byte = m;
        f = frames;
        wait (frames != f);
        @(negedge clk);
    endtask : frame
    task automatic pop(input logic [7:0] d, input logic l);
        int n;
        for (n = 0; n < 64 && mon_valid !== 1'b1; n++) @(negedge clk);
        `CHK("mon_word", {d, l}, {mon_data, mon_last})
        mon_ready = 1'b1;
        @(negedge clk);
        mon_ready = 1'b0;
    endtask : pop
    task automatic t_reset();
        `CHK("rst_out", 6'h00, {du_oe, ss, sup_en, codec_en, mon_valid})
        frame(8'h03, 8'hff);
        frame(8'h03, 8'hff);
    endtask : t_reset
    task automatic t_write();
        frame(8'h5a, 8'h81);
        `CHK("ss_pend", 2'h0, ss)
        frame(8'h5a, 8'h81);
        `CHK("st_a", 7'h5b, {gp, ss, sup_en, codec_en})
        frame(8'h36, 8'h81);
        `CHK("up_ack", 4'h0, {up_ind[7:5], up_ind[1]})
        frame(8'h66, 8'h5c);
        `CHK("st_hold", 7'h5b, {gp, ss, sup_en, codec_en})
        frame(8'h66, 8'h5c);
        `CHK("st_c", 7'h66, {gp, ss, sup_en, codec_en})
        frame(8'h1a, 8'h5c);
        frame(8'h66, 8'h3e);
        frame(8'h1a, 8'h3e);
        frame(8'h66, 8'h3e);
        `CHK("st_keep", 7'h66, {gp, ss, sup_en, codec_en})
        frame(8'h67, 8'hff);
        frame(8'h67, 8'hff);
        pop(8'h81, 1'b0);
        pop(8'h5c, 1'b0);
        pop(8'h3e, 1'b1);
        `CHK("fifo_empty", 1'b0, mon_valid)
    endtask : t_write
    task automatic t_read();
        {sig_mask, sig_status, resp_data} = 24'hf080a7;
        {ring, below, resp_last, resp_valid} = 4'hf;
        frame(8'h67, 8'hff);
        `CHK("sum_mask", 1'b0, summary)
        sig_status = 8'h81;
        frame(8'h67, 8'hff);
        `CHK("up_addr", 9'h102, {up_mon, up_ind[0]})
        `CHK("sum_liu", 2'h2, {summary, line_in_use})
        frame(8'h65, 8'hff);
        `CHK("up_sum", 2'h3, up_ind[4:3])
        sig_clear = 1'b1;
        @(negedge clk);
        sig_clear = 1'b0;
        frame(8'h67, 8'hff);
        `CHK("up_data", 9'h14e, {up_mon, up_ind[0]})
        `CHK("sum_clr", 1'b0, summary)
        `CHK("n_resp", 1, n_resp)
        frame(8'h65, 8'hff);
        `CHK("up_rep", 8'ha7, up_mon)
        frame(8'h67, 8'hff);
        `CHK("eom1", 1'b1, up_ind[0])
        frame(8'h67, 8'hff);
        `CHK("eom2", 4'h7, {up_ind[4:2], up_ind[0]})
    endtask : t_read
    initial begin
        {rst, sig_clear, ring, below, mon_ready, resp_valid, resp_last} = 7'h40;
        {sig_status, sig_mask, resp_data} = '0;
        c_byte = 8'h03;
        m_byte = 8'hff;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_write();
        t_read();
        give_verdict();
    end
endmodule : gsm_chan_bench
`default_nettype wire
